// *** hw/gpp_pkg.sv ***
package gpp_pkg;

    localparam int unsigned GPP_DATA_W   = 8;
    localparam int unsigned GPP_ADDR_W   = 8;
    localparam int unsigned GPP_PA_W     = 6;
    localparam int unsigned GPP_PB_W     = 8;
    localparam int unsigned GPP_CFG_W    = 3;
    localparam int unsigned GPP_SYNC_LEN = 3;

    // register offsets
    localparam logic [7:0] GPP_OFF_PA_DATA = 8'h05;
    localparam logic [7:0] GPP_OFF_PB_DATA = 8'h06;
    localparam logic [7:0] GPP_OFF_ICTL    = 8'h0B;
    localparam logic [7:0] GPP_OFF_OPTION  = 8'h81;
    localparam logic [7:0] GPP_OFF_PA_DIR  = 8'h85;
    localparam logic [7:0] GPP_OFF_PB_DIR  = 8'h86;
    localparam logic [7:0] GPP_OFF_ACFG    = 8'h9F;

    // field positions
    localparam int unsigned GPP_OPT_PULLUP_DIS_N = 7;
    localparam int unsigned GPP_OPT_EDGE_SEL     = 6;
    localparam int unsigned GPP_ICTL_CHG_FLAG    = 0;
    localparam int unsigned GPP_ICTL_EXT_FLAG    = 1;
    localparam int unsigned GPP_ICTL_CHG_EN      = 3;
    localparam int unsigned GPP_ICTL_EXT_EN      = 4;
    localparam int unsigned GPP_PA_OD_BIT        = 4;
    localparam int unsigned GPP_PB_EXT_INT_BIT   = 0;
    localparam int unsigned GPP_PB_CHG_LO        = 4;

    // reset values
    localparam logic [5:0] GPP_PA_DIR_RST  = 6'h3F;
    localparam logic [7:0] GPP_PB_DIR_RST  = 8'hFF;
    localparam logic [7:0] GPP_OPTION_RST  = 8'hFF;
    localparam logic [2:0] GPP_ACFG_RST    = 3'h0;
    localparam logic [5:0] GPP_PA_DATA_RST = 6'h00;
    localparam logic [7:0] GPP_PB_DATA_RST = 8'h00;
    localparam logic [5:0] GPP_PA_KEEP     = 6'h10;

    // analog pin masks selected by the config field
    localparam logic [5:0] GPP_AN_ALL  = 6'h2F;
    localparam logic [5:0] GPP_AN_LOW  = 6'h0B;
    localparam logic [5:0] GPP_AN_NONE = 6'h00;

endpackage : gpp_pkg

// *** hw/gpp_ports.sv ***
`timescale 1ns/1ps
module gpp_ports #(
    parameter bit HAS_ADC = 1'b1
) (
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic                           por_reset,
    input  wire logic [gpp_pkg::GPP_ADDR_W-1:0] reg_addr,
    input  wire logic [gpp_pkg::GPP_DATA_W-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [gpp_pkg::GPP_DATA_W-1:0] reg_rdata,
    input  wire logic [gpp_pkg::GPP_PA_W-1:0]   pa_in,
    output logic      [gpp_pkg::GPP_PA_W-1:0]   pa_out,
    output logic      [gpp_pkg::GPP_PA_W-1:0]   pa_oe,
    input  wire logic [gpp_pkg::GPP_PA_W-1:0]   pa_alt_en,
    input  wire logic [gpp_pkg::GPP_PB_W-1:0]   pb_in,
    output logic      [gpp_pkg::GPP_PB_W-1:0]   pb_out,
    output logic      [gpp_pkg::GPP_PB_W-1:0]   pb_oe,
    output logic      [gpp_pkg::GPP_PB_W-1:0]   pb_pullup_en,
    output logic      [gpp_pkg::GPP_PA_W-1:0]   analog_sel,
    output logic                                timer_zero_clock_in,
    output logic                                port_change_flag,
    output logic                                ext_int_flag,
    output logic                                wake_req
);
    import gpp_pkg::*;

    // change reference and its compare are four bits wide
    if (GPP_PB_W - GPP_PB_CHG_LO != 4 || GPP_PA_OD_BIT >= GPP_PA_W) begin : g_chk
        $error("gpp_ports: port widths do not match change or open drain logic");
    end

    function automatic logic [GPP_PA_W-1:0] an_mask(input logic [GPP_CFG_W-1:0] cfg);
        logic [GPP_PA_W-1:0] m;
        m = GPP_AN_NONE;
        case (cfg)
            3'h0, 3'h1, 3'h2, 3'h3: m = GPP_AN_ALL;
            3'h4, 3'h5:             m = GPP_AN_LOW;
            default:                m = GPP_AN_NONE;
        endcase
        return m;
    endfunction : an_mask

    logic [GPP_PA_W-1:0]  pa_pin;
    logic [GPP_PB_W-1:0]  pb_pin;
    logic [GPP_PA_W-1:0]  pa_lat_q;
    logic [GPP_PA_W-1:0]  pa_dir_q;
    logic [GPP_PB_W-1:0]  pb_lat_q;
    logic [GPP_PB_W-1:0]  pb_dir_q;
    logic [GPP_DATA_W-1:0] opt_q;
    logic [GPP_CFG_W-1:0] acfg_q;
    logic                 chg_flag_q;
    logic                 ext_flag_q;
    logic                 chg_en_q;
    logic                 ext_en_q;
    logic [3:0]           chg_ref_q;
    logic                 int_pin_q;
    logic [GPP_DATA_W-1:0] rdata_q;
    logic [GPP_DATA_W-1:0] rdata_d;
    logic [GPP_PA_W-1:0]  an_now;
    logic [GPP_PA_W-1:0]  pa_digital;
    logic [GPP_PA_W-1:0]  wdata_pa;
    logic [3:0]           pb_hi;
    logic                 chg_mismatch;
    logic                 ext_edge;
    logic                 wr_pa;
    logic                 wr_pb;
    logic                 wr_pa_dir;
    logic                 wr_pb_dir;
    logic                 wr_opt;
    logic                 wr_acfg;
    logic                 wr_ictl;
    logic                 rd_pb;

    // pins come from outside the clock domain
    gpp_sync3 #(.WIDTH(GPP_PA_W)) u_sync_pa (
        .clk   (clk),
        .reset (reset),
        .din   (pa_in),
        .dout  (pa_pin)
    );

    gpp_sync3 #(.WIDTH(GPP_PB_W)) u_sync_pb (
        .clk   (clk),
        .reset (reset),
        .din   (pb_in),
        .dout  (pb_pin)
    );

    assign wr_pa     = reg_wr && (reg_addr == GPP_OFF_PA_DATA);
    assign wr_pb     = reg_wr && (reg_addr == GPP_OFF_PB_DATA);
    assign wr_pa_dir = reg_wr && (reg_addr == GPP_OFF_PA_DIR);
    assign wr_pb_dir = reg_wr && (reg_addr == GPP_OFF_PB_DIR);
    assign wr_opt    = reg_wr && (reg_addr == GPP_OFF_OPTION);
    assign wr_acfg   = reg_wr && (reg_addr == GPP_OFF_ACFG) && HAS_ADC;
    assign wr_ictl   = reg_wr && (reg_addr == GPP_OFF_ICTL);
    assign rd_pb     = reg_rd && (reg_addr == GPP_OFF_PB_DATA);
    assign wdata_pa  = reg_wdata[GPP_PA_W-1:0];

    // no converter means no analog pins at all
    assign an_now     = HAS_ADC ? an_mask(acfg_q) : GPP_AN_NONE;
    assign analog_sel = an_now;
    // analog pins read zero on the digital path
    assign pa_digital = pa_pin & ~an_now;
    assign timer_zero_clock_in = pa_pin[GPP_PA_OD_BIT];

    // first port latch; the core merges pin state into write data
    always_ff @(posedge clk) begin
        if (reset) begin
            if (por_reset) begin
                pa_lat_q <= GPP_PA_DATA_RST;
            end else begin
                pa_lat_q <= pa_lat_q & GPP_PA_KEEP;
            end
        end else if (wr_pa) begin
            pa_lat_q <= wdata_pa;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pa_dir_q <= GPP_PA_DIR_RST;
        end else if (wr_pa_dir) begin
            pa_dir_q <= wdata_pa;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            acfg_q <= GPP_ACFG_RST;
        end else if (wr_acfg) begin
            acfg_q <= reg_wdata[GPP_CFG_W-1:0];
        end
    end

    // second port latch keeps its value over resets other than power-on
    always_ff @(posedge clk) begin
        if (reset && por_reset) begin
            pb_lat_q <= GPP_PB_DATA_RST;
        end else if (!reset && wr_pb) begin
            pb_lat_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pb_dir_q <= GPP_PB_DIR_RST;
        end else if (wr_pb_dir) begin
            pb_dir_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            opt_q <= GPP_OPTION_RST;
        end else if (wr_opt) begin
            opt_q <= reg_wdata;
        end
    end

    // first port drivers; direction still governs analog pins
    for (genvar i = 0; i < GPP_PA_W; i++) begin : g_pa_pin
        if (i == GPP_PA_OD_BIT) begin : g_od
            // open drain: enable only to pull low
            assign pa_out[i] = 1'b0;
            assign pa_oe[i]  = ~pa_dir_q[i] & ~pa_alt_en[i] & ~pa_lat_q[i];
        end else begin : g_pp
            assign pa_out[i] = pa_lat_q[i];
            assign pa_oe[i]  = ~pa_dir_q[i] & ~pa_alt_en[i];
        end
    end

    assign pb_out       = pb_lat_q;
    assign pb_oe        = ~pb_dir_q;
    // one switch for all pins, but never on a pin that drives
    assign pb_pullup_en = pb_dir_q & {GPP_PB_W{~opt_q[GPP_OPT_PULLUP_DIS_N]}};

    // change detection on upper inputs against the value at the last port b read or write
    assign pb_hi        = pb_pin[GPP_PB_W-1:GPP_PB_CHG_LO];
    assign chg_mismatch = |((pb_hi ^ chg_ref_q) & pb_dir_q[GPP_PB_W-1:GPP_PB_CHG_LO]);

    // polling relatches the reference, but a change in the read cycle still sets the flag
    always_ff @(posedge clk) begin
        if (reset) begin
            chg_ref_q <= 4'h0;
        end else if (rd_pb || wr_pb) begin
            chg_ref_q <= pb_hi;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            int_pin_q <= 1'b0;
        end else begin
            int_pin_q <= pb_pin[GPP_PB_EXT_INT_BIT];
        end
    end

    assign ext_edge = opt_q[GPP_OPT_EDGE_SEL]
                    ? (pb_pin[GPP_PB_EXT_INT_BIT] & ~int_pin_q)
                    : (~pb_pin[GPP_PB_EXT_INT_BIT] & int_pin_q);

    // flags: a hardware set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (reset) begin
            chg_flag_q <= 1'b0;
        end else if (chg_mismatch) begin
            chg_flag_q <= 1'b1;
        end else if (wr_ictl) begin
            chg_flag_q <= reg_wdata[GPP_ICTL_CHG_FLAG];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_flag_q <= 1'b0;
        end else if (ext_edge) begin
            ext_flag_q <= 1'b1;
        end else if (wr_ictl) begin
            ext_flag_q <= reg_wdata[GPP_ICTL_EXT_FLAG];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            chg_en_q <= 1'b0;
            ext_en_q <= 1'b0;
        end else if (wr_ictl) begin
            chg_en_q <= reg_wdata[GPP_ICTL_CHG_EN];
            ext_en_q <= reg_wdata[GPP_ICTL_EXT_EN];
        end
    end

    assign port_change_flag = chg_flag_q;
    assign ext_int_flag     = ext_flag_q;
    // works without the core clock gating, so sleep logic can use it
    assign wake_req = (chg_flag_q & chg_en_q) | (ext_flag_q & ext_en_q);

    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            GPP_OFF_PA_DATA: rdata_d = {2'h0, pa_digital};
            GPP_OFF_PB_DATA: rdata_d = pb_pin;
            GPP_OFF_PA_DIR:  rdata_d = {2'h0, pa_dir_q};
            GPP_OFF_PB_DIR:  rdata_d = pb_dir_q;
            GPP_OFF_OPTION:  rdata_d = opt_q;
            GPP_OFF_ACFG:    rdata_d = HAS_ADC ? {5'h00, acfg_q} : 8'h00;
            GPP_OFF_ICTL: begin
                rdata_d[GPP_ICTL_CHG_FLAG] = chg_flag_q;
                rdata_d[GPP_ICTL_EXT_FLAG] = ext_flag_q;
                rdata_d[GPP_ICTL_CHG_EN]   = chg_en_q;
                rdata_d[GPP_ICTL_EXT_EN]   = ext_en_q;
            end
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_pa_dir_reset: assert property ($fell(reset) |-> pa_dir_q == GPP_PA_DIR_RST)
        else $error("port a direction not all ones after reset");
    chk_pb_dir_reset: assert property ($fell(reset) |-> pb_dir_q == GPP_PB_DIR_RST)
        else $error("port b direction not all ones after reset");
    chk_analog_reset: assert property (
        $fell(reset) |-> analog_sel == (HAS_ADC ? GPP_AN_ALL : GPP_AN_NONE))
        else $error("analog pins not analog after reset");
    chk_input_floats: assert property ((pa_oe & pa_dir_q) == 6'h00)
        else $error("input pin of port a is driven");
    chk_od_low_only: assert property (pa_oe[GPP_PA_OD_BIT] |-> !pa_out[GPP_PA_OD_BIT])
        else $error("open drain pin driven high");
    chk_pb_input_floats: assert property ((pb_oe & pb_dir_q) == 8'h00)
        else $error("input pin of port b is driven");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not cleared outside a read");
    chk_pa_read_pins: assert property (
        (reg_rd && reg_addr == GPP_OFF_PA_DATA) |=> reg_rdata == {2'h0, $past(pa_digital)})
        else $error("port a read does not show pins");
    chk_pa_write_latch: assert property (wr_pa |=> pa_lat_q == $past(wdata_pa))
        else $error("port a write not latched");
    chk_pullup_disable: assert property (
        opt_q[GPP_OPT_PULLUP_DIS_N] |-> pb_pullup_en == 8'h00)
        else $error("pull-up on while disabled");
    chk_pullup_output: assert property ((pb_pullup_en & ~pb_dir_q) == 8'h00)
        else $error("pull-up on an output pin");
    chk_change_sets: assert property (chg_mismatch |=> chg_flag_q [*1])
        else $error("mismatch did not set change flag");
    chk_change_outputs: assert property (
        (pb_dir_q[7:4] == 4'h0 && !chg_flag_q && !wr_ictl) |=> !chg_flag_q)
        else $error("output pin set change flag");
    chk_read_relatch: assert property ((rd_pb || wr_pb) |=> chg_ref_q == $past(pb_hi))
        else $error("port b access did not relatch reference");
    chk_ext_edge: assert property (ext_edge |=> ext_flag_q)
        else $error("selected edge did not set external flag");
    chk_wake_change: assert property ((chg_flag_q && chg_en_q) |-> wake_req)
        else $error("enabled change flag did not wake");
    chk_no_adc_cfg: assert property (
        (!HAS_ADC && reg_rd && reg_addr == GPP_OFF_ACFG) |=> reg_rdata == 8'h00)
        else $error("config register present without converter");

    cov_change_wake: cover property (chg_mismatch ##1 wake_req);
    cov_ext_int: cover property (ext_edge ##1 ext_flag_q);
    cov_od_pull_low: cover property (pa_oe[GPP_PA_OD_BIT]);
    cov_read_clears: cover property (chg_flag_q && rd_pb ##1 !chg_mismatch);

endmodule : gpp_ports

// *** hw/gpp_sync3.sv ***
`timescale 1ns/1ps
module gpp_sync3 #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import gpp_pkg::*;

    if (WIDTH < 1) begin : g_chk
        $error("gpp_sync3: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] filt_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit only moves once two later stages agree, so a glitch is dropped
    for (genvar i = 0; i < WIDTH; i++) begin : g_filt
        always_ff @(posedge clk) begin
            if (reset) begin
                filt_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                filt_q[i] <= s3_q[i];
            end
        end
    end

    assign dout = filt_q;

endmodule : gpp_sync3

// *** verification/gpp_board.sv ***
`timescale 1ns/1ps
module gpp_board (
    input  wire logic       clk,
    input  wire logic [5:0] pa_out,
    input  wire logic [5:0] pa_oe,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pb_pullup_en,
    input  wire logic [5:0] ext_pa_en,
    input  wire logic [5:0] ext_pa_val,
    input  wire logic [7:0] ext_pb_en,
    input  wire logic [7:0] ext_pb_val,
    output logic      [5:0] pa_in,
    output logic      [7:0] pb_in
);
    logic [7:0] float_q;

    // undriven lines wander every cycle so a stale level is never trusted
    initial float_q = 8'h5A;
    always @(posedge clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pa_oe[i]) begin
                pa_in[i] = pa_out[i];
            end else if (ext_pa_en[i]) begin
                pa_in[i] = ext_pa_val[i];
            end else if (i == 4) begin
                pa_in[i] = 1'b1; // resistor on the open-drain line
            end else begin
                pa_in[i] = float_q[i];
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (pb_oe[i]) begin
                pb_in[i] = pb_out[i];
            end else if (ext_pb_en[i]) begin
                pb_in[i] = ext_pb_val[i];
            end else if (pb_pullup_en[i]) begin
                pb_in[i] = 1'b1;
            end else begin
                pb_in[i] = float_q[i];
            end
        end
    end
endmodule : gpp_board

// *** verification/test_gpp_ports.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_count++; \
    $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module test_gpp_ports;
    import gpp_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} gpp_row_s;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       por_reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [5:0] pa_alt_en = 6'h00;
    logic [5:0] ext_pa_en = 6'h00;
    logic [5:0] ext_pa_val = 6'h00;
    logic [7:0] ext_pb_en = 8'h00;
    logic [7:0] ext_pb_val = 8'h00;
    logic [7:0] reg_rdata, rdata2, q, q2;
    logic [5:0] pa_in, pa_out, pa_oe, analog_sel, asel2;
    logic [7:0] pb_in, pb_out, pb_oe, pb_pullup_en;
    logic       timer_zero_clock_in, port_change_flag, ext_int_flag, wake_req;
    int         err_count = 0;
    int         compares = 0;
    gpp_row_s   rows [8] = '{
        '{1'b0, 8'h85, 8'h00, 8'h3F}, '{1'b0, 8'h86, 8'h00, 8'hFF},
        '{1'b0, 8'h9F, 8'h00, 8'h00}, '{1'b0, 8'h81, 8'h00, 8'hFF},
        '{1'b0, 8'h40, 8'h00, 8'h00}, '{1'b1, 8'h85, 8'hFF, 8'h00},
        '{1'b0, 8'h85, 8'h00, 8'h3F}, '{1'b0, 8'h0B, 8'h00, 8'h00}};

    always #50 clk = ~clk;

    gpp_ports #(.HAS_ADC(1'b1)) i_gpp_ports (.clk(clk), .reset(reset), .por_reset(por_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
        .pa_alt_en(pa_alt_en), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
        .pb_pullup_en(pb_pullup_en), .analog_sel(analog_sel),
        .timer_zero_clock_in(timer_zero_clock_in), .port_change_flag(port_change_flag),
        .ext_int_flag(ext_int_flag), .wake_req(wake_req));
    // variant without converter shares bus and pins, only its config side is watched
    gpp_ports #(.HAS_ADC(1'b0)) i_gpp_ports_noadc (.clk(clk), .reset(reset),
        .por_reset(por_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata2), .pa_in(pa_in), .pa_out(), .pa_oe(),
        .pa_alt_en(pa_alt_en), .pb_in(pb_in), .pb_out(), .pb_oe(), .pb_pullup_en(),
        .analog_sel(asel2), .timer_zero_clock_in(), .port_change_flag(),
        .ext_int_flag(), .wake_req());
    gpp_board i_gpp_board (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
        .pb_oe(pb_oe), .pb_pullup_en(pb_pullup_en), .ext_pa_en(ext_pa_en),
        .ext_pa_val(ext_pa_val), .ext_pb_en(ext_pb_en), .ext_pb_val(ext_pb_val),
        .pa_in(pa_in), .pb_in(pb_in));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
        q2 = rdata2;
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic do_reset(input logic por);
        @(posedge clk);
        por_reset <= por;
        reset <= 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        #1;
    endtask : do_reset

    task automatic test_end(input string nm);
        $display("test %s done, %0d mismatches so far", nm, err_count);
    endtask : test_end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #(100 * 5000);
        err_count++;
        finish_test;
    end

    initial begin
        do_reset(1'b1);
        `CHK("pa_oe", 6'h00, pa_oe)
        `CHK("pb_oe", 8'h00, pb_oe)
        `CHK("pullup", 8'h00, pb_pullup_en)
        `CHK("analog_sel", 6'h2F, analog_sel)
        `CHK("asel2", 6'h00, asel2)
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else begin
                rd(rows[i].a);
                `CHK("reg", rows[i].e, q)
            end
        end
        wr(8'h9F, 8'h07);
        rd(8'h9F);
        `CHK("cfg", 8'h07, q)
        `CHK("cfg2", 8'h00, q2)
        test_end("registers");
        wr(8'h9F, 8'h06);
        `CHK("analog_sel", 6'h00, analog_sel)
        wr(8'h85, 8'h00);
        wr(8'h05, 8'h2A);
        `CHK("pa_out", 6'h2A, pa_out)
        `CHK("pa_oe", 6'h3F, pa_oe)
        wr(8'h05, 8'h3F);
        `CHK("pa_out", 6'h2F, pa_out)
        `CHK("pa_oe", 6'h2F, pa_oe)
        wait_cyc(6);
        rd(8'h05);
        `CHK("pa_pins", 8'h3F, q)
        `CHK("tmr_clk", 1'b1, timer_zero_clock_in)
        wr(8'h05, 8'h2F);
        wait_cyc(6);
        `CHK("tmr_clk", 1'b0, timer_zero_clock_in)
        pa_alt_en <= 6'h01;
        wait_cyc(1);
        `CHK("pa_oe", 6'h3E, pa_oe)
        pa_alt_en <= 6'h00;
        wr(8'h85, 8'h3F);
        `CHK("pa_oe", 6'h00, pa_oe)
        ext_pa_en <= 6'h3F;
        ext_pa_val <= 6'h15;
        wait_cyc(6);
        rd(8'h05);
        `CHK("pa_pins", 8'h15, q)
        wr(8'h9F, 8'h04);
        ext_pa_val <= 6'h3F;
        wait_cyc(6);
        rd(8'h05);
        `CHK("pa_mix", 8'h34, q)
        `CHK("analog_sel", 6'h0B, analog_sel)
        test_end("port_a");
        wr(8'h86, 8'hF0);
        wr(8'h06, 8'hA5);
        `CHK("pb_out", 8'hA5, pb_out)
        `CHK("pb_oe", 8'h0F, pb_oe)
        wr(8'h81, 8'h7F);
        `CHK("pullup", 8'hF0, pb_pullup_en)
        ext_pb_en <= 8'hF0;
        ext_pb_val <= 8'h00;
        wait_cyc(6);
        rd(8'h06);
        wr(8'h0B, 8'h08);
        `CHK("chg", 1'b0, port_change_flag)
        ext_pb_val <= 8'h10;
        wait_cyc(7);
        `CHK("chg", 1'b1, port_change_flag)
        `CHK("wake", 1'b1, wake_req)
        wr(8'h0B, 8'h08);
        wait_cyc(2);
        `CHK("chg", 1'b1, port_change_flag)
        rd(8'h06);
        `CHK("pb_pins", 8'h15, q)
        wr(8'h0B, 8'h08);
        wait_cyc(2);
        `CHK("chg", 1'b0, port_change_flag)
        wr(8'h86, 8'hE0);
        wait_cyc(6);
        rd(8'h06);
        wr(8'h0B, 8'h08);
        wr(8'h06, 8'hB5);
        wait_cyc(7);
        `CHK("chg", 1'b0, port_change_flag)
        wr(8'h86, 8'h00);
        wr(8'h06, 8'h4A);
        `CHK("pb_oe", 8'hFF, pb_oe)
        wait_cyc(7);
        `CHK("chg", 1'b0, port_change_flag)
        test_end("port_b");
        wr(8'h86, 8'hFF);
        ext_pb_en <= 8'hFF;
        ext_pb_val <= 8'h00;
        wait_cyc(6);
        wr(8'h0B, 8'h10);
        `CHK("ext", 1'b0, ext_int_flag)
        ext_pb_val <= 8'h01;
        wait_cyc(7);
        `CHK("ext", 1'b1, ext_int_flag)
        `CHK("wake", 1'b1, wake_req)
        wr(8'h81, 8'h3F);
        `CHK("pullup", 8'hFF, pb_pullup_en)
        wr(8'h0B, 8'h10);
        `CHK("ext", 1'b0, ext_int_flag)
        ext_pb_val <= 8'h00;
        wait_cyc(7);
        `CHK("ext", 1'b1, ext_int_flag)
        test_end("ext_int");
        wr(8'h05, 8'h10);
        do_reset(1'b0);
        `CHK("pb_oe", 8'h00, pb_oe)
        `CHK("analog_sel", 6'h2F, analog_sel)
        wr(8'h85, 8'h00);
        `CHK("pa_oe", 6'h2F, pa_oe)
        do_reset(1'b1);
        `CHK("pullup", 8'h00, pb_pullup_en)
        wr(8'h85, 8'h00);
        `CHK("pa_oe", 6'h3F, pa_oe)
        test_end("resets");
        finish_test;
    end
endmodule : test_gpp_ports
